// ===== core/clhp_port.sv
// parallel host port of a character display controller
// assumes the host drives select, read/write, enable and bus from outside the clock domain
//
// Notes on behaviour
// - two 8-bit registers exist: one for instruction codes, one for RAM data in transit.
// - the select input picks the instruction side when low and the data side when high.
// - the instruction register can be written but never read back by the host.
// - select,rw of 00 writes an instruction, 01 reads status, 10 writes RAM, 11 reads RAM.
// - a status read puts the busy flag on the top bus line and the address counter below it.
// - the address counter is seven bits wide, read on lines 0 to 6.
// - every RAM byte the host writes or reads passes through the data holding register.
// - writing an address instruction fetches the addressed byte into the data holding register.
// - while an internal operation runs the busy flag is high and instructions are ignored.
// - each RAM write or read made while not busy steps the address counter by one in the configured direction.
// - eight two-way lines carry data; the host drives on writes, the device on reads.
// - line one maps to addresses 00 to 07 and line two to 40 to 47, hexadecimal.
`timescale 1ns/1ns
`include "clhp_cfg.svh"
module clhp_port import clhp_pkg::*; #(
  parameter int INSTR_CYC = `CLHP_INSTR_BUSY,
  parameter int DATA_CYC  = `CLHP_DATA_BUSY
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  // host control pins
  input  wire logic       i_reg_select,
  input  wire logic       i_rw,
  input  wire logic       i_en,
  // parallel_bus_lines, split three ways
  input  wire logic [7:0] i_bus,
  output logic      [7:0] o_bus,
  output logic            o_bus_oe,
  // status view
  output logic            o_busy_flag,
  output logic      [6:0] o_addr_counter
);
  typedef struct packed {
    clhp_state_t st;
    logic [7:0]  instr_reg;
    logic [7:0]  data_hold_reg;
    logic [6:0]  addr_counter;
    logic        sel_glyph;
    logic        incr;
    logic [15:0] cnt;
    logic        en_d;
    logic [7:0]  rd_byte;
    logic        oe;
    logic        clr_run;
  } clhp_port_st_t;
  clhp_port_st_t st_r, st_nxt;

  // longest busy stretch: the longer count plus the fetch cycle and one spare
  localparam int BUSY_MAX = ((INSTR_CYC > DATA_CYC) ? INSTR_CYC : DATA_CYC) + 2;

  logic [10:0] pin_s;
  logic        rs_s, rw_s, en_s;
  logic [7:0]  bus_s;
  logic        en_rise, en_fall;
  clhp_ram_if  ram_bus ();

  // synchronise every pin
  clhp_sync #(.W(11)) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     ({i_reg_select, i_rw, i_en, i_bus}),
    .o_q     (pin_s)
  );
  assign {rs_s, rw_s, en_s, bus_s} = pin_s;
  assign en_rise = en_s && !st_r.en_d;
  assign en_fall = !en_s && st_r.en_d;

  clhp_ram u_ram (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .ram     (ram_bus.mem)
  );

  // next state: decode accesses, run internal operations
  always_comb begin
    st_nxt      = st_r;
    st_nxt.en_d = en_s;
    ram_bus.we        = 1'b0;
    ram_bus.sel_glyph = st_r.sel_glyph;
    ram_bus.addr      = st_r.addr_counter;
    ram_bus.wdata     = st_r.data_hold_reg;
    // read strobe high: present status or RAM byte
    if (en_rise && rw_s) begin
      st_nxt.oe = 1'b1;
      if (!rs_s) begin
        st_nxt.rd_byte = {st_r.st != CLHP_IDLE, st_r.addr_counter};
      end else begin
        st_nxt.rd_byte = st_r.data_hold_reg;
      end
    end
    if (en_fall) begin
      st_nxt.oe = 1'b0;
    end
    case (st_r.st)
      CLHP_IDLE: begin
        // write: capture on falling strobe
        if (en_fall && !rw_s && !rs_s) begin
          st_nxt.instr_reg = bus_s;
          st_nxt.cnt       = 16'(INSTR_CYC);
          st_nxt.st        = CLHP_BUSY;
          if (bus_s == `CLHP_OP_CLEAR) begin
            st_nxt.addr_counter = `CLHP_ADDR_ZERO;
            st_nxt.sel_glyph    = 1'b0;
            st_nxt.incr         = 1'b1;
            st_nxt.clr_run      = 1'b1;
          end else if ((bus_s & `CLHP_MASK_HOME) == `CLHP_OP_HOME) begin
            st_nxt.addr_counter = `CLHP_ADDR_ZERO;
            st_nxt.sel_glyph    = 1'b0;
          end else if ((bus_s & `CLHP_MASK_ENTRY) == `CLHP_OP_ENTRY) begin
            st_nxt.incr = bus_s[1];
          end else if ((bus_s & `CLHP_MASK_DDADDR) == `CLHP_OP_DDADDR) begin
            st_nxt.addr_counter = bus_s[6:0];
            st_nxt.sel_glyph    = 1'b0;
            st_nxt.st           = CLHP_FETCH;
          end else if ((bus_s & `CLHP_MASK_CGADDR) == `CLHP_OP_CGADDR) begin
            st_nxt.addr_counter = {1'b0, bus_s[5:0]};
            st_nxt.sel_glyph    = 1'b1;
            st_nxt.st           = CLHP_FETCH;
          end
        end else if (en_fall && rs_s) begin
          // RAM write or read through the holding register
          if (!rw_s) begin
            ram_bus.wdata        = bus_s;
            ram_bus.we           = 1'b1;
            st_nxt.data_hold_reg = bus_s;
          end
          st_nxt.addr_counter = st_r.incr ? st_r.addr_counter + 7'h01
                                          : st_r.addr_counter - 7'h01;
          st_nxt.cnt = 16'(DATA_CYC);
          st_nxt.st  = CLHP_FETCH;
        end
      end
      CLHP_FETCH: begin
        // load the byte at the new address for a following read
        st_nxt.data_hold_reg = ram_bus.rdata;
        st_nxt.st            = CLHP_BUSY;
      end
      CLHP_BUSY: begin
        // blank the display cell by cell while clearing
        if (st_r.clr_run) begin
          ram_bus.we    = 1'b1;
          ram_bus.wdata = `CLHP_BLANK_CHAR;
          ram_bus.addr  = st_r.cnt[3] ? `CLHP_LINE2_BASE | 7'(st_r.cnt[2:0])
                                      : `CLHP_LINE1_BASE | 7'(st_r.cnt[2:0]);
        end
        // new instructions are ignored here
        if (st_r.cnt <= 16'h0001) begin
          st_nxt.st      = CLHP_IDLE;
          st_nxt.cnt     = '0;
          st_nxt.clr_run = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - 16'h0001;
        end
      end
      default: st_nxt.st = CLHP_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r      <= '0;
      st_r.incr <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs from flip-flops
  assign o_bus          = st_r.rd_byte;
  assign o_bus_oe       = st_r.oe;
  assign o_busy_flag    = st_r.st != CLHP_IDLE;
  assign o_addr_counter = st_r.addr_counter;

  // busy must fall within the instruction time
  AST_BUSY_ENDS: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(o_busy_flag) |-> ##[1:BUSY_MAX] !o_busy_flag)
    else $error("busy flag did not clear in time");
  // no instruction taken while busy
  AST_NO_INSTR_BUSY: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (o_busy_flag && st_r.st == CLHP_BUSY) |=> $stable(st_r.instr_reg))
    else $error("instruction register changed while busy");
  // status read shows busy on the top line
  AST_STATUS_BIT: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (en_rise && rw_s && !rs_s) |=> (o_bus[`CLHP_BUSY_BIT] == $past(o_busy_flag) && o_bus_oe))
    else $error("status byte lacks busy flag");
  // data access steps the counter by one
  AST_AC_STEP: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_r.st == CLHP_IDLE && en_fall && rs_s) |=>
      (o_addr_counter == $past(o_addr_counter) + 7'h01 || o_addr_counter == $past(o_addr_counter) - 7'h01))
    else $error("address counter did not step");
  // bus not driven by the port after a write strobe rises
  AST_OE_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (en_rise && !rw_s) |=> !o_bus_oe)
    else $error("bus driven on a write");
  // RAM write goes through the holding register
  AST_DR_WRITE: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_r.st == CLHP_IDLE && en_fall && rs_s && !rw_s) |=> st_r.data_hold_reg == $past(bus_s))
    else $error("holding register missed write byte");
  // address set leads to fetch then busy
  AST_FETCH: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_r.st == CLHP_FETCH) |=> (st_r.st == CLHP_BUSY && st_r.data_hold_reg == $past(ram_bus.rdata)))
    else $error("fetch did not load the holding register");
  // instruction capture on select low write
  AST_IR_LOAD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_r.st == CLHP_IDLE && en_fall && !rs_s && !rw_s) |=> (st_r.instr_reg == $past(bus_s) && o_busy_flag))
    else $error("instruction not captured");
endmodule : clhp_port

// ===== core/clhp_cfg.svh
// constants for the character display host port
// assumes inclusion by bare name from clhp files only
`ifndef CLHP_CFG_SVH
`define CLHP_CFG_SVH
`define CLHP_LINE1_BASE   7'h00
`define CLHP_LINE1_LAST   7'h07
`define CLHP_LINE2_BASE   7'h40
`define CLHP_LINE2_LAST   7'h47
`define CLHP_BUSY_BIT     7
`define CLHP_INSTR_BUSY   16'h0008
`define CLHP_DATA_BUSY    16'h0004
`define CLHP_OP_CLEAR     8'h01
`define CLHP_MASK_HOME    8'hfe
`define CLHP_OP_HOME      8'h02
`define CLHP_MASK_ENTRY   8'hfc
`define CLHP_OP_ENTRY     8'h04
`define CLHP_MASK_CGADDR  8'hc0
`define CLHP_OP_CGADDR    8'h40
`define CLHP_MASK_DDADDR  8'h80
`define CLHP_OP_DDADDR    8'h80
`define CLHP_BLANK_CHAR   8'h20
`define CLHP_ADDR_ZERO    7'h00
`define CLHP_GLYPH_PATTERN_RAM_AW     6
`endif

// ===== core/clhp_pkg.sv
// types shared by the character display host port
// assumes clhp_cfg.svh is on the include path
package clhp_pkg;
  typedef enum logic [1:0] {
    CLHP_IDLE  = 2'b00,
    CLHP_FETCH = 2'b01,
    CLHP_BUSY  = 2'b11
  } clhp_state_t;
endpackage : clhp_pkg

// ===== core/clhp_ram_if.sv
// interface between the port logic and its display and glyph stores
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface clhp_ram_if;
  logic       we;        // write strobe
  logic       sel_glyph; // high selects glyph store
  logic [6:0] addr;      // word index
  logic [7:0] wdata;     // write byte
  logic [7:0] rdata;     // read byte, same cycle
  modport port (output we, output sel_glyph, output addr, output wdata, input rdata);
  modport mem  (input we, input sel_glyph, input addr, input wdata, output rdata);
endinterface : clhp_ram_if

// ===== core/clhp_ram.sv
// display char store and glyph pattern store in flip-flops
// assumes a synchronous active-low reset on i_mclk
`timescale 1ns/1ns
`include "clhp_cfg.svh"
module clhp_ram import clhp_pkg::*; #(
  parameter int DW = 8
) (
  // clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // access from the port
  clhp_ram_if.mem   ram
);
  localparam int GN = 1 << `CLHP_GLYPH_PATTERN_RAM_AW;
  typedef struct packed {
    logic [15:0][DW-1:0] disp;
    logic [GN-1:0][DW-1:0] glyph;
  } clhp_ram_st_t;
  clhp_ram_st_t st_r, st_nxt;
  logic [2:0] col;
  logic       line_ok;

  // map the two display lines onto eight cells each
  assign col     = ram.addr[2:0];
  assign line_ok = (ram.addr >= `CLHP_LINE1_BASE && ram.addr <= `CLHP_LINE1_LAST) ||
                   (ram.addr >= `CLHP_LINE2_BASE && ram.addr <= `CLHP_LINE2_LAST);

  // read mux, unmapped display cells read as zero
  always_comb begin
    if (ram.sel_glyph) begin
      ram.rdata = st_r.glyph[ram.addr[`CLHP_GLYPH_PATTERN_RAM_AW-1:0]];
    end else if (line_ok) begin
      ram.rdata = st_r.disp[{ram.addr[6], col}];
    end else begin
      ram.rdata = '0;
    end
  end

  // write path
  always_comb begin
    st_nxt = st_r;
    if (ram.we && ram.sel_glyph) begin
      st_nxt.glyph[ram.addr[`CLHP_GLYPH_PATTERN_RAM_AW-1:0]] = ram.wdata;
    end else if (ram.we && line_ok) begin
      st_nxt.disp[{ram.addr[6], col}] = ram.wdata;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule : clhp_ram

// ===== core/clhp_sync.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes inputs are asynchronous to i_mclk
`timescale 1ns/1ns
module clhp_sync #(
  parameter int W = 11
) (
  // clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst_n,
  // pins in, synchronised out
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } clhp_sync_st_t;
  clhp_sync_st_t st_r, st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt.s1 = i_d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign o_q = st_r.s2;
endmodule : clhp_sync

// ===== tb/clhp_host.sv
// host processor model driving the parallel port pins
// assumes the bench resolves the shared bus lines and calls the tasks
`timescale 1ns/1ns
module clhp_host (
  // clock
  input  wire logic       i_mclk,
  // resolved bus lines
  input  wire logic [7:0] i_bus_line,
  // control pins
  output logic            o_reg_select,
  output logic            o_rw,
  output logic            o_en,
  // host side of the bus
  output logic            o_drive,
  output logic      [7:0] o_wdata,
  // read results and hang flag
  output logic            o_rd_valid,
  output logic      [7:0] o_rd_data,
  output logic            o_hang
);
  // pins idle at time zero
  initial begin
    o_reg_select = 1'b0;
    o_rw         = 1'b1;
    o_en         = 1'b0;
    o_drive      = 1'b0;
    o_wdata      = 8'h00;
    o_rd_valid   = 1'b0;
    o_hang       = 1'b0;
  end
  // one byte access: controls settle first, strobe high six cycles, data held long after the fall
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d, input logic chk, output logic [7:0] q);
    @(negedge i_mclk);
    o_reg_select = rs;
    o_rw         = rw;
    o_wdata      = d;
    o_drive      = ~rw;
    @(negedge i_mclk);
    o_en = 1'b1;
    repeat (6) @(posedge i_mclk);
    q = i_bus_line;
    @(negedge i_mclk);
    o_en       = 1'b0;
    o_rd_data  = q;
    o_rd_valid = chk & rw;
    @(negedge i_mclk);
    o_rd_valid = 1'b0;
    repeat (5) @(negedge i_mclk);
    o_drive = 1'b0;
  endtask : acc
  // poll status until the busy bit reads low, bounded
  task automatic wait_idle();
    logic [7:0] s;
    int         n;
    for (n = 0; n < 40; n++) begin
      acc(1'b0, 1'b1, 8'h00, 1'b0, s);
      if (s[7] === 1'b0) break;
    end
    if (n == 40) o_hang = 1'b1;
  endtask : wait_idle
endmodule : clhp_host

// ===== tb/tb_top.sv
// self-checking bench for the character display host port
// assumes clhp_port with its stores and the host model compiled before it
`timescale 1ns/1ns
module tb_top;
  logic       i_mclk;
  logic       i_rst_n;
  logic       rs;
  logic       rw;
  logic       en;
  logic       drv;
  logic       rd_valid;
  logic       hang;
  logic       dut_oe;
  logic       busy;
  logic [6:0] ac;
  logic [7:0] wdata;
  logic [7:0] rd_data;
  logic [7:0] dut_bus;
  logic [7:0] bus_line;
  logic [7:0] idle_pat;
  logic [7:0] tmp;
  logic [7:0] mem [0:15];
  logic [7:0] exp_q [$];
  int         err_count;
  int         check_count;
  // released lines show a pattern that changes every cycle
  assign bus_line = dut_oe ? dut_bus : (drv ? wdata : idle_pat);
  always @(posedge i_mclk) idle_pat <= idle_pat + 8'h01;
  // clock
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  clhp_port #(.INSTR_CYC(40), .DATA_CYC(4)) clhp_port_i (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_reg_select(rs), .i_rw(rw), .i_en(en), .i_bus(bus_line),
    .o_bus(dut_bus), .o_bus_oe(dut_oe), .o_busy_flag(busy), .o_addr_counter(ac));
  clhp_host clhp_host_i (
    .i_mclk(i_mclk), .i_bus_line(bus_line), .o_reg_select(rs), .o_rw(rw), .o_en(en), .o_drive(drv),
    .o_wdata(wdata), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_hang(hang));
  // verdict and end of run
  task automatic stop_test();
    $display("counts: checks=%0d mismatches=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // access then wait for the port to go idle
  task automatic op(input logic rs_v, input logic rw_v, input logic [7:0] d);
    logic [7:0] q;
    clhp_host_i.acc(rs_v, rw_v, d, rw_v, q);
    clhp_host_i.wait_idle();
  endtask : op
  // note the expected byte, then read it
  task automatic expect_rd(input logic rs_v, input logic [7:0] e);
    exp_q.push_back(e);
    op(rs_v, 1'b1, 8'h00);
  endtask : expect_rd
  // compare every checked read against the oldest note
  always @(posedge i_mclk) begin
    if (rd_valid === 1'b1) begin
      check_count++;
      if (exp_q.size() == 0 || rd_data !== exp_q[0]) begin
        err_count++;
        $display("CHECK FAILED t=%0t read %h", $time, rd_data);
      end
      if (exp_q.size() > 0) void'(exp_q.pop_front());
    end
  end
  // a poll that never saw idle ends the run
  always @(posedge hang) begin
    err_count++;
    $display("CHECK FAILED t=%0t busy never cleared", $time);
    stop_test();
  end
  // main sequence
  initial begin
    i_rst_n     = 1'b0;
    idle_pat    = 8'h00;
    err_count   = 0;
    check_count = 0;
    void'($urandom(13));
    repeat (4) @(posedge i_mclk);
    @(negedge i_mclk) i_rst_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    check_count++;
    if (busy !== 1'b0 || ac !== 7'h00 || dut_oe !== 1'b0) begin
      err_count++;
      $display("CHECK FAILED t=%0t reset state", $time);
    end
    expect_rd(1'b0, 8'h00);
    $display("test reset done");
    // fill both display lines with random bytes, then read them back
    for (int l = 0; l < 2; l++) begin
      op(1'b0, 1'b0, (l == 1) ? 8'hc0 : 8'h80);
      for (int i = 0; i < 8; i++) begin
        mem[l*8+i] = 8'($urandom);
        op(1'b1, 1'b0, mem[l*8+i]);
      end
      expect_rd(1'b0, (l == 1) ? 8'h48 : 8'h08);
      op(1'b0, 1'b0, (l == 1) ? 8'hc0 : 8'h80);
      for (int i = 0; i < 8; i++) expect_rd(1'b1, mem[l*8+i]);
    end
    $display("test fill and read lines done");
    // decrement direction
    op(1'b0, 1'b0, 8'h04);
    op(1'b0, 1'b0, 8'hc5);
    tmp = 8'($urandom);
    mem[13] = tmp;
    op(1'b1, 1'b0, tmp);
    expect_rd(1'b0, 8'h44);
    op(1'b0, 1'b0, 8'hc5);
    expect_rd(1'b1, tmp);
    expect_rd(1'b0, 8'h44);
    op(1'b0, 1'b0, 8'h06);
    $display("test decrement done");
    // accesses during busy: status shows busy, write is dropped
    clhp_host_i.acc(1'b0, 1'b0, 8'h83, 1'b0, tmp);
    exp_q.push_back(8'h83);
    clhp_host_i.acc(1'b0, 1'b1, 8'h00, 1'b1, tmp);
    clhp_host_i.acc(1'b1, 1'b0, ~mem[3], 1'b0, tmp);
    clhp_host_i.wait_idle();
    expect_rd(1'b0, 8'h03);
    op(1'b0, 1'b0, 8'h83);
    expect_rd(1'b1, mem[3]);
    $display("test busy refusal done");
    // clear returns the counter to zero
    op(1'b0, 1'b0, 8'h01);
    expect_rd(1'b0, 8'h00);
    op(1'b0, 1'b0, 8'h83);
    expect_rd(1'b1, 8'h20);
    $display("test clear done");
    stop_test();
  end
endmodule : tb_top
